// >>> spi_ext_model.sv
// Purpose: external serial devices facing the controller
// Assumes: 64 ns link clock, mode 0 framing, msb first
// Notes: link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_ext_model (
  input wire logic master_sclk,
  input wire logic master_sel_n,
  input wire logic master_mosi,
  output logic sclk,
  output logic select_n,
  output logic mosi,
  output logic miso
);
  localparam logic [7:0] reply = 8'h96;
  logic [7:0] rx_byte;
  logic [7:0] pulses;
  int bitpos;
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
    miso = 1'b1;
    rx_byte = 8'h00;
    pulses = 8'h00;
    bitpos = 0;
  end
  // selected slave: reply msb first, next bit after each falling edge
  always @(negedge master_sel_n) begin
    bitpos = 7;
    pulses = 8'h00;
    miso = reply[7];
  end
  // released line goes to its pull-up level
  always @(posedge master_sel_n) begin
    miso = 1'b1;
  end
  always @(negedge master_sclk) begin
    if (!master_sel_n && bitpos > 0) begin
      bitpos = bitpos - 1;
      miso = reply[bitpos];
    end
  end
  // every rising edge in a frame is counted, so a stray pulse shows
  always @(posedge master_sclk) begin
    if (!master_sel_n) begin
      rx_byte = {rx_byte[6:0], master_mosi};
      pulses = pulses + 8'h01;
    end
  end
  // frame of one character; nothing is read back, no underrun seen
  task automatic send(input logic [7:0] d);
    #13 select_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 select_n = 1'b1;
    mosi = ~mosi;
  endtask : send
endmodule : spi_ext_model
`default_nettype wire

// >>> spi_link_if.sv
// Purpose: carries slave-side link results into the system clock domain
// Assumes: toggle handshake for each received character
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic [7:0] rx_word;
  logic rx_toggle;
  logic [7:0] tx_word;
  modport link (output rx_word, output rx_toggle, input tx_word);
  modport core (input rx_word, input rx_toggle, output tx_word);
endinterface : spi_link_if
`default_nettype wire

// >>> spi_master_slave_controller.sv
// Purpose: serial master/slave controller with the documented quirks
// Assumes: control bits arrive as plain ports from system-clock logic
// Notes: slave link runs on its own clock, results cross by toggle
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_cmd,
  input wire logic disable_cmd,
  input wire logic software_reset_bit,
  input wire logic slave_mode,
  input wire logic mode_fault_disable,
  input wire logic [1:0] select_index,
  input wire logic [7:0] serial_clock_divisor,
  input wire logic [7:0] prev_divisor,
  input wire logic clock_polarity,
  input wire logic clock_phase_bit,
  input wire logic keep_select_after_transfer,
  input wire logic tx_write,
  input wire logic [7:0] transmit_data_register,
  input wire logic rx_read,
  input wire logic sclk_in,
  input wire logic select_in_n,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic miso_out,
  output logic miso_oe,
  output logic [3:0] select_out_n,
  output logic enabled,
  output logic transmit_empty_flag,
  output logic receive_ready_flag,
  output logic [7:0] receive_holding_register
);
  spi_link_if lnk();
  logic slave_miso;
  logic link_clear;
  spi_slave_link u_link (
    .sclk(sclk_in),
    .select_n(select_in_n),
    .mosi(mosi_in),
    .clear(link_clear),
    .lk(lnk.link),
    .miso(slave_miso)
  );
  //////////////////////////////////////////////////////////////////////////
  // crossings: toggle through four flops, data through two, before use
  logic tg1, tg2, tg3, tg4, sel1, sel2, miso1, miso2, pol_prev;
  logic [7:0] rxw1, rxw2;
  always_ff @(posedge clk) begin
    tg1 <= lnk.rx_toggle;
    tg2 <= tg1;
    tg3 <= tg2;
    tg4 <= tg3;
    link_clear <= reset || software_reset_bit;
    rxw1 <= lnk.rx_word;
    rxw2 <= rxw1;
    sel1 <= select_in_n;
    sel2 <= sel1;
    miso1 <= miso_in;
    miso2 <= miso1;
    pol_prev <= clock_polarity;
  end
  // late toggle stage: the word copy has stood a full cycle by then
  wire slave_rx_event = tg3 ^ tg4;
  //////////////////////////////////////////////////////////////////////////
  spi_pkg::master_state_type state, next_state;
  logic [7:0] tx_hold, next_tx_hold, shift, next_shift, rx, next_rx;
  logic [7:0] div_cnt, next_div_cnt;
  logic [3:0] bits, next_bits;
  logic next_enabled, next_transmit_empty_flag, next_rdrf, next_sclk, next_mosi;
  logic extra_pulse, next_extra_pulse;
  logic [3:0] next_sel;
  logic hang;
  assign lnk.tx_word = tx_hold;
  // keep-select on select 0 with fault detection blocks any start
  assign hang = keep_select_after_transfer && !mode_fault_disable
    && (select_index == 2'h0);
  always_comb begin
    next_state = state;
    next_enabled = enabled;
    next_transmit_empty_flag = transmit_empty_flag;
    next_rdrf = receive_ready_flag;
    next_tx_hold = tx_hold;
    next_shift = shift;
    next_rx = receive_holding_register;
    next_div_cnt = div_cnt;
    next_bits = bits;
    next_sclk = sclk_out;
    next_mosi = mosi_out;
    next_sel = select_out_n;
    next_extra_pulse = 1'b0;
    if (enable_cmd) next_enabled = 1'b1;
    // disable ignored in slave mode; leaves the empty flag alone
    if (disable_cmd && !slave_mode) next_enabled = 1'b0;
    if (rx_read) next_rdrf = 1'b0;
    // writes while disabled are dropped, dma words included
    if (tx_write && enabled) begin
      next_tx_hold = transmit_data_register;
      next_transmit_empty_flag = 1'b0;
    end
    if (slave_mode) begin
      next_state = spi_pkg::st_idle;
      next_sclk = clock_polarity;
      if (slave_rx_event && enabled) begin
        next_rx = rxw2;
        next_rdrf = 1'b1;
        next_transmit_empty_flag = 1'b1;
      end
      // false receive-ready on enable or on a polarity flip
      if ((enable_cmd && !enabled) || (pol_prev != clock_polarity)) begin
        next_rdrf = 1'b1;
      end
    end else begin
      unique case (state)
        spi_pkg::st_idle: begin
          next_sclk = clock_polarity;
          if (!keep_select_after_transfer) next_sel = 4'hf;
          if (enabled && !transmit_empty_flag && !hang) begin
            next_shift = tx_hold;
            // a write landing at the start stays pending
            next_transmit_empty_flag = !(tx_write && enabled);
            next_bits = spi_pkg::bit_count_reset;
            next_div_cnt = serial_clock_divisor;
            next_sel = ~(4'h1 << select_index);
            next_mosi = tx_hold[7];
            next_state = spi_pkg::st_lead;
            // mixed divisors with polarity high, phase clear
            next_extra_pulse = clock_polarity && !clock_phase_bit
              && (select_index != 2'h0)
              && (prev_divisor == spi_pkg::divisor_reset)
              && (serial_clock_divisor != spi_pkg::divisor_reset);
            if (next_extra_pulse) next_sclk = ~clock_polarity;
          end
        end
        spi_pkg::st_lead: begin
          next_sclk = clock_polarity;
          if (div_cnt <= 8'h1) begin
            next_div_cnt = serial_clock_divisor;
            next_sclk = ~clock_polarity;
            next_state = spi_pkg::st_trail;
          end else next_div_cnt = div_cnt - 8'h1;
        end
        spi_pkg::st_trail: begin
          if (div_cnt <= 8'h1) begin
            next_div_cnt = serial_clock_divisor;
            next_sclk = clock_polarity;
            // miso taken late: the synchroniser lag would catch the old bit
            next_shift = {shift[6:0], miso2};
            next_mosi = shift[6];
            next_bits = bits + 4'h1;
            next_state = spi_pkg::st_lead;
            if (bits + 4'h1 == spi_pkg::bits_per_char) begin
              next_rx = {shift[6:0], miso2};
              next_rdrf = 1'b1;
              next_state = spi_pkg::st_idle;
            end
          end else next_div_cnt = div_cnt - 8'h1;
        end
        default: next_state = spi_pkg::st_idle;
      endcase
    end
  end
  // only reset or software reset can stop a slave
  always_ff @(posedge clk) begin
    if (reset || software_reset_bit) begin
      state <= spi_pkg::st_idle;
      enabled <= 1'b0;
      transmit_empty_flag <= 1'b1;
      receive_ready_flag <= 1'b0;
      tx_hold <= spi_pkg::data_reset;
      shift <= spi_pkg::data_reset;
      receive_holding_register <= spi_pkg::data_reset;
      div_cnt <= spi_pkg::divisor_reset;
      bits <= spi_pkg::bit_count_reset;
      sclk_out <= 1'b0;
      mosi_out <= 1'b0;
      select_out_n <= 4'hf;
      extra_pulse <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      state <= next_state;
      enabled <= next_enabled;
      transmit_empty_flag <= next_transmit_empty_flag;
      receive_ready_flag <= next_rdrf;
      tx_hold <= next_tx_hold;
      shift <= next_shift;
      receive_holding_register <= next_rx;
      div_cnt <= next_div_cnt;
      bits <= next_bits;
      sclk_out <= next_sclk;
      mosi_out <= next_mosi;
      select_out_n <= next_sel;
      extra_pulse <= next_extra_pulse;
      miso_out <= slave_miso;
      miso_oe <= slave_mode && enabled && !sel2;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_DROP_WRITE: assert property (@(posedge clk) disable iff (reset)
    tx_write && !enabled && !software_reset_bit && transmit_empty_flag
      |=> transmit_empty_flag)
    else $error("write while disabled cleared empty flag");
  AST_SLAVE_DIS: assert property (@(posedge clk) disable iff (reset)
    enabled && slave_mode && disable_cmd && !software_reset_bit |=> enabled)
    else $error("slave disabled by command");
  AST_HANG: assert property (@(posedge clk) disable iff (reset)
    state == spi_pkg::st_idle && hang && !slave_mode
      |=> state == spi_pkg::st_idle)
    else $error("transfer started while hung");
  AST_SOFTWARE_RESET_BIT: assert property (@(posedge clk) disable iff (reset)
    software_reset_bit |=> !enabled && transmit_empty_flag)
    else $error("software reset did not stop");
  AST_DISABLE_TRANSMIT_EMPTY_FLAG: assert property (@(posedge clk) disable iff (reset)
    disable_cmd && !tx_write && !software_reset_bit && !slave_mode
      && state == spi_pkg::st_idle
      && (transmit_empty_flag || hang || !enabled)
      |=> transmit_empty_flag == $past(transmit_empty_flag))
    else $error("disable changed empty flag");
  AST_FALSE_RDY: assert property (@(posedge clk) disable iff (reset)
    slave_mode && enable_cmd && !enabled && !software_reset_bit
      |=> receive_ready_flag)
    else $error("enable glitch missing");
  AST_EXTRA: assert property (@(posedge clk) disable iff (reset)
    extra_pulse && !software_reset_bit |-> sclk_out != clock_polarity)
    else $error("extra pulse absent");
  AST_ENABLE: assert property (@(posedge clk) disable iff (reset)
    enable_cmd && !software_reset_bit && !(disable_cmd && !slave_mode)
      |=> enabled)
    else $error("enable not taken");
  CV_MASTER: cover property (@(posedge clk) state == spi_pkg::st_trail);
  CV_SLAVE_RX: cover property (@(posedge clk) slave_mode && slave_rx_event);
  CV_HANG: cover property (@(posedge clk) hang && !transmit_empty_flag);
endmodule : spi_master_slave_controller
`default_nettype wire

// >>> spi_master_slave_controller_tb_top.sv
// Purpose: self-checking bench for the serial controller
// Assumes: 10 MHz clk, command pulses driven by nba on rising edge
// Notes: software workaround sequences are played as port pulses
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_controller_tb_top;
  logic clk = 1'b0, reset = 1'b1, en = 1'b0, dis = 1'b0, swr = 1'b0;
  logic slv = 1'b0, mfd = 1'b0, pol = 1'b0, pha = 1'b0, keep = 1'b0;
  logic txw = 1'b0, rxr = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] div = 8'h02, txd = 8'h00, pdiv = 8'h02;
  logic sck_o, mosi_o, miso_o, miso_oe, enabled, empty, ready;
  logic sck_i, sel_i_n, mosi_i, miso_i;
  logic [3:0] sel_o_n;
  logic [7:0] hold;
  int err_total = 0, checks_done = 0, cycles = 0;
  always #50 clk = ~clk;
  spi_master_slave_controller u_dut (.clk(clk), .reset(reset),
    .enable_cmd(en), .disable_cmd(dis), .software_reset_bit(swr),
    .slave_mode(slv), .mode_fault_disable(mfd), .select_index(sel),
    .serial_clock_divisor(div), .prev_divisor(pdiv),
    .clock_polarity(pol), .clock_phase_bit(pha),
    .keep_select_after_transfer(keep), .tx_write(txw),
    .transmit_data_register(txd), .rx_read(rxr), .sclk_in(sck_i),
    .select_in_n(sel_i_n), .mosi_in(mosi_i), .miso_in(miso_i),
    .sclk_out(sck_o), .mosi_out(mosi_o), .miso_out(miso_o),
    .miso_oe(miso_oe), .select_out_n(sel_o_n), .enabled(enabled),
    .transmit_empty_flag(empty), .receive_ready_flag(ready),
    .receive_holding_register(hold));
  spi_ext_model u_ext (.master_sclk(sck_o), .master_sel_n(&sel_o_n),
    .master_mosi(mosi_o),
    .sclk(sck_i), .select_n(sel_i_n), .mosi(mosi_i), .miso(miso_i));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // one-cycle pulse: 0 enable, 1 disable, 2 swreset, 3 txwrite, 4 rxread
  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: en <= 1'b1;
      1: dis <= 1'b1;
      2: swr <= 1'b1;
      3: txw <= 1'b1;
      default: rxr <= 1'b1;
    endcase
    @(posedge clk);
    {en, dis, swr, txw, rxr} <= 5'h00;
  endtask : cmd
  task automatic look(input int n);
    repeat (n) @(negedge clk);
  endtask : look
  // bounded wait on the settled ready flag or on select 0 going low
  task automatic wait_for(input logic want_ready);
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (want_ready ? ready === 1'b1 : sel_o_n[0] === 1'b0) break;
    end
    chk(n < 400, 1'b1);
  endtask : wait_for
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    look(1);
    chk({enabled, empty, ready, sck_o, miso_oe}, 8'h08);
    chk(sel_o_n, 4'hf);
    cmd(3); // write while disabled is dropped
    look(3);
    chk(empty, 1'b1);
    cmd(0);
    look(2);
    chk(enabled, 1'b1);
    // keep-select on select 0 with fault detection: stalls
    keep <= 1'b1;
    txd <= 8'h3c;
    cmd(3);
    look(40);
    chk(sel_o_n, 4'hf);
    chk(empty, 1'b0);
    cmd(1);
    look(2);
    chk({enabled, empty}, 8'h00);
    // dma keeps feeding a disabled controller: words vanish
    repeat (3) cmd(3);
    look(20);
    chk({empty, sel_o_n}, 8'h0f);
    mfd <= 1'b1;
    cmd(0);
    wait_for(1'b0);
    wait_for(1'b1);
    chk(empty, 1'b1);
    chk(u_ext.rx_byte, 8'h3c);
    chk(hold, 8'h96);
    cmd(4);
    look(2);
    chk(ready, 1'b0);
    cmd(2); // software reset returns to reset state
    look(2);
    chk({enabled, empty, ready}, 8'h02);
    // slave start-up sequence against a false ready
    slv <= 1'b1;
    cmd(0);
    look(1);
    chk(ready, 1'b1);
    @(posedge clk) pol <= 1'b1;
    @(posedge clk) pol <= 1'b0;
    look(6);
    cmd(4);
    look(2);
    chk(ready, 1'b0);
    cmd(1);
    look(2);
    chk(enabled, 1'b1);
    u_ext.send(8'ha5);
    wait_for(1'b1);
    chk(hold, 8'ha5);
    cmd(4);
    cmd(2);
    look(2);
    chk(enabled, 1'b0);
    // polarity high on select 1 while the other divisor is 1
    slv <= 1'b0;
    keep <= 1'b0;
    pol <= 1'b1;
    sel <= 2'h1;
    pdiv <= 8'h01;
    txd <= 8'h81;
    cmd(0);
    cmd(3);
    wait_for(1'b1);
    chk(u_ext.pulses, 8'h09);
    div <= 8'h01;
    cmd(4);
    cmd(3);
    wait_for(1'b1);
    chk(u_ext.pulses, 8'h08);
    pol <= 1'b0;
    sel <= 2'h0;
    div <= 8'h02;
    txd <= 8'h5c;
    cmd(4);
    cmd(3);
    wait_for(1'b1);
    chk(u_ext.rx_byte, 8'h5c);
    chk(hold, 8'h96);
    // pause: writes stop first, then the controller goes off
    look(2);
    cmd(1);
    look(1);
    chk({enabled, empty}, 8'h01);
    cmd(0);
    cmd(4);
    txd <= 8'h3a;
    cmd(3);
    wait_for(1'b1);
    chk(u_ext.rx_byte, 8'h3a);
    give_verdict();
  end
endmodule : spi_master_slave_controller_tb_top
`default_nettype wire

// >>> spi_pkg.sv
// Purpose: constants and types for the serial controller
// Assumes: 10 MHz system clock, 8-bit characters, four chip selects
package spi_pkg;
  localparam int data_width = 8;
  localparam int num_selects = 4;
  localparam int divisor_width = 8;
  localparam logic [3:0] bit_count_reset = 4'h0;
  localparam logic [3:0] bits_per_char = 4'h8;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [7:0] divisor_reset = 8'h01;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_lead = 2'b01,
    st_trail = 2'b10
  } master_state_type;
endpackage : spi_pkg

// >>> spi_slave_link.sv
// Purpose: slave shift register clocked by the incoming serial clock
// Assumes: mode 0 style sampling on rising edge; select low frames a char
// Notes: link clock only runs inside a frame
`timescale 1ns/1ps
`default_nettype none
module spi_slave_link (
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic clear,
  spi_link_if.link lk,
  output logic miso
);
  logic [2:0] count;
  logic [7:0] shift;
  logic [7:0] word;
  logic toggle;
  logic [2:0] next_count;
  logic [7:0] next_shift;
  logic [7:0] next_word;
  logic next_toggle;
  // sampled on rising edge; count restarts with the frame's own select and wraps to zero after eight edges
  always_comb begin
    next_count = count + 3'h1;
    next_shift = {shift[6:0], mosi};
    next_word = word;
    next_toggle = toggle;
    // first edge loads the reply behind the bit already on the line
    if (count == 3'h0) next_shift = {lk.tx_word[6:0], mosi};
    if (count == 3'h7) begin
      next_word = {shift[6:0], mosi};
      next_toggle = ~toggle;
    end
  end
  always_ff @(posedge sclk or posedge select_n) begin
    if (select_n) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
    end
  end
  // cleared from the system side so the crossing toggle starts known
  always_ff @(posedge sclk or posedge clear) begin
    if (clear) begin
      shift <= 8'h00;
      word <= 8'h00;
      toggle <= 1'b0;
    end else begin
      shift <= next_shift;
      word <= next_word;
      toggle <= next_toggle;
    end
  end
  // no underrun: a stale tx word is resent silently
  assign miso = (count == 3'h0) ? lk.tx_word[7] : shift[7];
  assign lk.rx_word = word;
  assign lk.rx_toggle = toggle;
endmodule : spi_slave_link
`default_nettype wire
